// ==== design/dma_ctrl.sv ====
// Purpose: two-channel cycle-stealing dma controller
// Assumes: memory answers mem_rdata in the last cycle of a read access
// Notes:   all outputs are registered
//
// Overview of operation
// (RULE1) two channels steal bus cycles, owning the bus ahead of the cpu
// (RULE2) triggers ignore cpu interrupt enable and level; interrupts untouched
// (RULE3) one transfer per trigger on an enabled channel; fast triggers merge
// (RULE4) modes: forward source, forward destination, or both fixed; never both forward
// (RULE5) own register range 0x00020 to 0x0003F is never accessed by transfers
// (RULE6) sixteen-bit transfer counter per channel
// (RULE7) triggers: pin 0 falling or both edges, pin 1 falling, peripherals, software
// (RULE8) simultaneous triggers: channel zero is served first
// (RULE9) each transfer moves one byte or one word per unit setting
// (RULE10) single mode underflow clears enable, channel goes inactive
// (RULE11) repeat mode underflow reloads counter; stays enabled until software clears
// (RULE12) counter underflow raises the channel interrupt request
// (RULE13) first transfer after enable loads forward pointer and counter
// (RULE14) forward pointer always writable; fixed pointer only while disabled
// (RULE15) registers always readable; enabled forward pointer reads live value
// (RULE16) transfer is source read cycles followed by destination write cycles
// (RULE17) odd word addresses add one read and one write cycle
// (RULE18) peripheral area or waited memory access lengthens cycle by one clock
// (RULE19) request bit set on trigger always, cleared at start; software clears only
// (RULE20) writing enable one restarts the channel with full reload
// (RULE21) after channel zero, bus returns to cpu one access before channel one
// (RULE22) forward pointer steps by unit size, counter decrements by one
// (RULE23) pointers are twenty bits wide
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module dma_ctrl
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic [dma_pkg::RADDR_W-1:0] reg_addr,
  input  wire logic [dma_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [dma_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        ext_irq_pin_0,
  input  wire logic                        ext_irq_pin_1,
  input  wire logic [dma_pkg::NUM_PERIPH-1:0] periph_irq,
  input  wire logic                        mem_sw_wait,
  input  wire logic [dma_pkg::DATA_W-1:0]  mem_rdata,
  output logic                             bus_own,
  output logic                             mem_req,
  output dma_pkg::bus_op_s                 mem_op,
  output logic      [1:0]                  chan_irq
);
  import dma_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic wr_hit(input logic c, input logic [3:0] off);
    wr_hit = reg_wr && (reg_addr[7:5] == PAGE_DMA) && (reg_addr[4] == c)
             && (reg_addr[3:0] == off);
  endfunction

  function automatic logic in_own_regs(input logic [19:0] a);
    in_own_regs = (a >= DMA_REG_LO) && (a <= DMA_REG_HI);
  endfunction

  function automatic logic needs_wait(input logic [19:0] a);
    needs_wait = (a <= SFR_END) || mem_sw_wait;
  endfunction

  // ==========================================================
  // channel state
  chan_ctrl_s        ctrl     [2];
  logic [4:0]        sel      [2];
  // (RULE23) twenty-bit pointers
  logic [19:0]       src_ptr  [2];
  logic [19:0]       dst_ptr  [2];
  logic [19:0]       fwd_ptr  [2];
  logic [15:0]       reload   [2];
  // (RULE6) sixteen-bit transfer counter
  logic [15:0]       cnt      [2];
  logic              first    [2];
  logic [19:0]       cur_src  [2];
  logic [19:0]       cur_dst  [2];
  logic [1:0]        trig;
  logic [1:0]        xfer_start;
  logic [1:0]        xfer_done;

  // ==========================================================
  // external pin synchronisers and edge detect
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_fall;
  logic [1:0] pin_rise;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pin_s1 <= 2'b11;
      pin_s2 <= 2'b11;
      pin_s3 <= 2'b11;
    end
    else
    begin
      pin_s1 <= {ext_irq_pin_1, ext_irq_pin_0};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign pin_fall = pin_s3 & ~pin_s2;
  assign pin_rise = ~pin_s3 & pin_s2;

  // ==========================================================
  // trigger selection and current addresses
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      trig[c] = 1'b0;
      // (RULE7) source select
      if (sel[c] == SEL_SOFT)
        trig[c] = wr_hit(c[0], OFF_SWTRIG);
      else if (sel[c] == SEL_PINFALL)
        trig[c] = pin_fall[c];
      else if (sel[c] == SEL_PINBOTH && c == 0)
        trig[c] = pin_fall[0] | pin_rise[0];
      else if (sel[c] >= SEL_PERIPH && sel[c] < SEL_PERIPH + 5'(NUM_PERIPH))
        trig[c] = periph_irq[4'(sel[c] - SEL_PERIPH)];
      // (RULE13) first transfer takes the programmed pointer
      cur_src[c] = (ctrl[c].src_fwd && !first[c]) ? fwd_ptr[c] : src_ptr[c];
      cur_dst[c] = (ctrl[c].dst_fwd && !first[c]) ? fwd_ptr[c] : dst_ptr[c];
    end
  end

  // ==========================================================
  // engine
  eng_state_e  state;
  logic        x_ch;
  logic        x_word;
  logic [19:0] x_src;
  logic [19:0] x_dst;
  logic        part;
  logic        wait_left;
  logic [15:0] buf_q;
  logic        go0;
  logic        go1;
  logic        pick;
  logic        split_rd;
  logic        split_wr;
  logic        l_launch;
  logic        l_finish;
  bus_op_s     l_op;
  logic [15:0] next_buf;

  // (RULE1) (RULE2) enabled request is served whatever the cpu state
  assign go0 = ctrl[0].enable && ctrl[0].req;
  assign go1 = ctrl[1].enable && ctrl[1].req;
  // (RULE8) channel zero wins a tie
  assign pick = !go0;
  // (RULE17) odd word halves split into two byte cycles
  assign split_rd = x_word && x_src[0];
  assign split_wr = x_word && x_dst[0];

  always_comb
  begin
    l_launch = 1'b0;
    l_finish = 1'b0;
    l_op = '0;
    next_buf = buf_q;
    xfer_start = 2'b00;
    case (state)
      ST_IDLE:
      begin
        if (go0 || go1)
        begin
          l_launch = 1'b1;
          xfer_start[pick] = 1'b1;
          l_op.addr = cur_src[pick];
          l_op.word = !ctrl[pick].unit_byte && !cur_src[pick][0];
        end
      end
      ST_READ:
      begin
        if (!wait_left)
        begin
          // (RULE9) assemble one byte or one word
          if (!x_word)
            next_buf = {8'h00, mem_rdata[7:0]};
          else if (!split_rd)
            next_buf = mem_rdata;
          else if (!part)
            next_buf = {buf_q[15:8], mem_rdata[7:0]};
          else
            next_buf = {mem_rdata[7:0], buf_q[7:0]};
          l_launch = 1'b1;
          // (RULE16) reads first, then writes
          if (split_rd && !part)
            l_op.addr = x_src + STEP_BYTE;
          else
          begin
            l_op.we = 1'b1;
            l_op.addr = x_dst;
            l_op.word = x_word && !x_dst[0];
            l_op.wdata = split_wr ? {8'h00, next_buf[7:0]} : next_buf;
          end
        end
      end
      ST_WRITE:
      begin
        if (!wait_left)
        begin
          if (split_wr && !part)
          begin
            l_launch = 1'b1;
            l_op.we = 1'b1;
            l_op.addr = x_dst + STEP_BYTE;
            l_op.wdata = {8'h00, buf_q[15:8]};
          end
          else
            l_finish = 1'b1;
        end
      end
      default:
      begin
        l_launch = 1'b0;
      end
    endcase
    xfer_done = {l_finish && x_ch, l_finish && !x_ch};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      bus_own <= 1'b0;
      mem_req <= 1'b0;
      mem_op <= '0;
      x_ch <= 1'b0;
      x_word <= 1'b0;
      x_src <= '0;
      x_dst <= '0;
      part <= 1'b0;
      wait_left <= 1'b0;
      buf_q <= '0;
    end
    else
    begin
      buf_q <= next_buf;
      if (wait_left)
        wait_left <= 1'b0;
      if (l_launch)
      begin
        mem_op <= l_op;
        // (RULE5) an access to the own register range never raises mem_req
        mem_req <= !in_own_regs(l_op.addr);
        // (RULE18) one extra clock for peripheral area or waited memory
        wait_left <= needs_wait(l_op.addr);
      end
      case (state)
        ST_IDLE:
        begin
          if (l_launch)
          begin
            state <= ST_READ;
            bus_own <= 1'b1;
            x_ch <= pick;
            x_word <= !ctrl[pick].unit_byte;
            x_src <= cur_src[pick];
            x_dst <= cur_dst[pick];
            part <= 1'b0;
          end
        end
        ST_READ:
        begin
          if (l_launch)
          begin
            part <= split_rd && !part;
            if (!(split_rd && !part))
              state <= ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          if (l_launch)
            part <= 1'b1;
          if (l_finish)
          begin
            // (RULE21) hand the bus back for one cpu access
            state <= ST_GAP;
            bus_own <= 1'b0;
            mem_req <= 1'b0;
            mem_op <= '0;
            part <= 1'b0;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // channel registers
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < 2; c++)
      begin
        ctrl[c] <= CTRL_RST;
        sel[c] <= SEL_SOFT;
        src_ptr[c] <= '0;
        dst_ptr[c] <= '0;
        fwd_ptr[c] <= '0;
        reload[c] <= '0;
        cnt[c] <= '0;
        first[c] <= 1'b1;
      end
      chan_irq <= 2'b00;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        chan_irq[c] <= xfer_done[c] && (cnt[c] == CNT_ZERO);
        if (xfer_start[c])
        begin
          // (RULE19) request drops as the transfer begins
          ctrl[c].req <= 1'b0;
          if (first[c])
          begin
            // (RULE13) load pointer and counter
            first[c] <= 1'b0;
            cnt[c] <= reload[c];
            fwd_ptr[c] <= ctrl[c].src_fwd ? src_ptr[c] : dst_ptr[c];
          end
        end
        if (xfer_done[c])
        begin
          // (RULE22) step pointer and count
          fwd_ptr[c] <= fwd_ptr[c] + (ctrl[c].unit_byte ? STEP_BYTE : STEP_WORD);
          // (RULE12) underflow event
          if (cnt[c] == CNT_ZERO)
          begin
            // (RULE11) repeat reloads counter
            if (ctrl[c].rpt)
              cnt[c] <= reload[c];
            // (RULE10) single mode stops
            else
              ctrl[c].enable <= 1'b0;
          end
          else
            cnt[c] <= cnt[c] - 16'h0001;
        end
        if (wr_hit(c[0], OFF_CTRL))
        begin
          ctrl[c].enable <= reg_wdata[BIT_EN];
          ctrl[c].unit_byte <= reg_wdata[BIT_BYTE];
          ctrl[c].rpt <= reg_wdata[BIT_RPT];
          // (RULE4) both forward is refused, source keeps priority
          ctrl[c].src_fwd <= reg_wdata[BIT_SFWD];
          ctrl[c].dst_fwd <= reg_wdata[BIT_DFWD] && !reg_wdata[BIT_SFWD];
          // (RULE20) enable write restarts from scratch
          if (reg_wdata[BIT_EN])
            first[c] <= 1'b1;
          if (!reg_wdata[BIT_REQ])
            ctrl[c].req <= 1'b0;
        end
        if (wr_hit(c[0], OFF_SEL))
          sel[c] <= reg_wdata[4:0];
        if (wr_hit(c[0], OFF_RELOAD))
          reload[c] <= reg_wdata;
        // (RULE14) fixed pointer locked while enabled
        if (ctrl[c].src_fwd || !ctrl[c].enable)
        begin
          if (wr_hit(c[0], OFF_SRC_LO))
            src_ptr[c][15:0] <= reg_wdata;
          if (wr_hit(c[0], OFF_SRC_HI))
            src_ptr[c][19:16] <= reg_wdata[3:0];
        end
        if (ctrl[c].dst_fwd || !ctrl[c].enable)
        begin
          if (wr_hit(c[0], OFF_DST_LO))
            dst_ptr[c][15:0] <= reg_wdata;
          if (wr_hit(c[0], OFF_DST_HI))
            dst_ptr[c][19:16] <= reg_wdata[3:0];
        end
        // (RULE19) (RULE3) trigger sets request, winning over a clear
        if (trig[c])
          ctrl[c].req <= 1'b1;
      end
    end
  end

  // ==========================================================
  // register read port
  logic        rc;
  logic [19:0] rd_src;
  logic [19:0] rd_dst;
  logic [15:0] next_rdata;

  always_comb
  begin
    rc = reg_addr[4];
    // (RULE15) enabled forward pointer reads the live address
    rd_src = (ctrl[rc].enable && ctrl[rc].src_fwd && !first[rc]) ? fwd_ptr[rc] : src_ptr[rc];
    rd_dst = (ctrl[rc].enable && ctrl[rc].dst_fwd && !first[rc]) ? fwd_ptr[rc] : dst_ptr[rc];
    next_rdata = 16'h0000;
    if (reg_rd && reg_addr[7:5] == PAGE_DMA)
    begin
      case (reg_addr[3:0])
        OFF_CTRL:   next_rdata = {10'h000, ctrl[rc]};
        OFF_SEL:    next_rdata = {11'h000, sel[rc]};
        OFF_SRC_LO: next_rdata = rd_src[15:0];
        OFF_SRC_HI: next_rdata = {12'h000, rd_src[19:16]};
        OFF_DST_LO: next_rdata = rd_dst[15:0];
        OFF_DST_HI: next_rdata = {12'h000, rd_dst[19:16]};
        OFF_RELOAD: next_rdata = reload[rc];
        OFF_COUNT:  next_rdata = cnt[rc];
        default:    next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else
      reg_rdata <= next_rdata;
  end

endmodule
`default_nettype wire

// ==== common/dma_pkg.sv ====
// Purpose: shared constants and types of the two-channel dma controller
// Assumes: 16-bit data bus, 20-bit address space, one clock
// Notes:   register offsets are per channel, channel stride is 16 words
package dma_pkg;

  // ==========================================================
  // widths and address ranges
  localparam int          ADDR_W      = 20;
  localparam int          DATA_W      = 16;
  localparam int          CNT_W       = 16;
  localparam int          RADDR_W     = 8;
  localparam logic [19:0] DMA_REG_LO  = 20'h00020;
  localparam logic [19:0] DMA_REG_HI  = 20'h0003F;
  localparam logic [19:0] SFR_END     = 20'h003FF;
  localparam logic [19:0] STEP_BYTE   = 20'h00001;
  localparam logic [19:0] STEP_WORD   = 20'h00002;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;

  // ==========================================================
  // register map, offset inside a channel block
  localparam logic [3:0]  OFF_CTRL    = 4'h0;
  localparam logic [3:0]  OFF_SEL     = 4'h1;
  localparam logic [3:0]  OFF_SRC_LO  = 4'h2;
  localparam logic [3:0]  OFF_SRC_HI  = 4'h3;
  localparam logic [3:0]  OFF_DST_LO  = 4'h4;
  localparam logic [3:0]  OFF_DST_HI  = 4'h5;
  localparam logic [3:0]  OFF_RELOAD  = 4'h6;
  localparam logic [3:0]  OFF_COUNT   = 4'h7;
  localparam logic [3:0]  OFF_SWTRIG  = 4'h8;
  localparam logic [2:0]  PAGE_DMA    = 3'h0;

  // control register bit positions
  localparam int          BIT_EN      = 0;
  localparam int          BIT_REQ     = 1;
  localparam int          BIT_BYTE    = 2;
  localparam int          BIT_RPT     = 3;
  localparam int          BIT_SFWD    = 4;
  localparam int          BIT_DFWD    = 5;

  // ==========================================================
  // trigger source select codes
  localparam logic [4:0]  SEL_SOFT    = 5'h00;
  localparam logic [4:0]  SEL_PINFALL = 5'h01;
  localparam logic [4:0]  SEL_PINBOTH = 5'h02;
  localparam logic [4:0]  SEL_PERIPH  = 5'h03;
  localparam int          NUM_PERIPH  = 16;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_GAP   = 2'b11
  } eng_state_e;

  typedef struct packed
  {
    logic dst_fwd;
    logic src_fwd;
    logic rpt;
    logic unit_byte;
    logic req;
    logic enable;
  } chan_ctrl_s;

  localparam chan_ctrl_s CTRL_RST = '0;

  typedef struct packed
  {
    logic        we;
    logic        word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } bus_op_s;

endpackage

// ==== verif/dma_ctrl_assertions.sv ====
// Purpose: port-level checks of the dma controller
// Assumes: one clock, synchronous active-low reset
// Notes:   sees only the ports of dma_ctrl
`timescale 1ns/10ps
`default_nettype none
module dma_ctrl_assertions
(
  input wire logic                           clk_sys,
  input wire logic                           rst_n,
  input wire logic                           reg_rd,
  input wire logic [dma_pkg::DATA_W-1:0]     reg_rdata,
  input wire logic                           mem_sw_wait,
  input wire logic                           bus_own,
  input wire logic                           mem_req,
  input wire dma_pkg::bus_op_s               mem_op,
  input wire logic [1:0]                     chan_irq
);
  import dma_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // sequences
  sequence gap_s;
    !bus_own ##1 !bus_own;
  endsequence
  sequence held_s;
    $stable(mem_op) && bus_own;
  endsequence
  // ==========================================================
  // assertions
  own_range_a: assert property (mem_req |-> !(mem_op.addr inside {[DMA_REG_LO:DMA_REG_HI]}))
    else $error("transfer touched the controller registers");
  rd_idle_a: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data outside its cycle");
  bus_first_a: assert property (mem_req |-> bus_own)
    else $error("access without bus ownership");
  irq_pulse_a: assert property (chan_irq != 2'b00 |=> chan_irq == 2'b00)
    else $error("interrupt longer than one cycle");
  irq_cause_a: assert property (chan_irq != 2'b00 |-> $past(bus_own) && $past(mem_op.we) && !bus_own)
    else $error("interrupt not at end of a transfer");
  gap_a: assert property ($fell(bus_own) |-> gap_s)
    else $error("bus not handed back between transfers");
  read_first_a: assert property ($rose(bus_own) |-> !mem_op.we)
    else $error("transfer did not start with a read");
  wait_len_a: assert property ($rose(bus_own) && mem_sw_wait |=> held_s)
    else $error("waited access shorter than two cycles");
  fast_access_a: assert property ($rose(bus_own) && !mem_sw_wait && mem_op.addr > SFR_END |=> $changed(mem_op))
    else $error("unwaited access longer than one cycle");
  odd_split_a: assert property (mem_req && mem_op.word |-> !mem_op.addr[0])
    else $error("word access at odd address");
endmodule

bind dma_ctrl dma_ctrl_assertions chk
(
  .clk_sys,
  .rst_n,
  .reg_rd,
  .reg_rdata,
  .mem_sw_wait,
  .bus_own,
  .mem_req,
  .mem_op,
  .chan_irq
);
`default_nettype wire

// ==== verif/mem_model.sv ====
// Purpose: byte memory on the far side of the dma bus
// Assumes: read data answered combinationally during the access
// Notes:   logs every write address for order checks
`timescale 1ns/10ps
`default_nettype none
module mem_model
(
  input  wire logic                       clk_sys,
  input  wire logic                       mem_req,
  input  wire dma_pkg::bus_op_s           mem_op,
  output logic [dma_pkg::DATA_W-1:0]      mem_rdata
);
  import dma_pkg::*;
  logic [7:0]  m [0:4095];
  logic [19:0] wlog [$];
  logic [15:0] last = 16'h5A5A;
  logic [11:0] a;
  logic        rd;
  assign a = mem_op.addr[11:0];
  assign rd = mem_req && !mem_op.we;
  // released bus shows the inverse of the last value
  always_comb
  begin
    if (!rd)
      mem_rdata = ~last;
    else if (mem_op.word)
      mem_rdata = {m[a + 12'h001], m[a]};
    else
      mem_rdata = {8'h00, m[a]};
  end
  always @(posedge clk_sys)
  begin
    if (rd)
      last <= mem_rdata;
    if (mem_req && mem_op.we)
    begin
      m[a] <= mem_op.wdata[7:0];
      if (mem_op.word)
        m[a + 12'h001] <= mem_op.wdata[15:8];
      wlog.push_back(mem_op.addr);
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench of the dma controller
// Assumes: 250 MHz clock, memory model on the bus side
// Notes:   registers reached over the plain strobe port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dma_pkg::*;
  logic                clk_sys;
  logic                rst_n = 1'b0;
  logic [RADDR_W-1:0]  reg_addr = 8'h00;
  logic [DATA_W-1:0]   reg_wdata = 16'h0000;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [DATA_W-1:0]   reg_rdata;
  logic                ext_irq_pin_0 = 1'b1;
  logic                ext_irq_pin_1 = 1'b1;
  logic [15:0]         periph_irq = 16'h0000;
  logic                mem_sw_wait = 1'b0;
  logic [DATA_W-1:0]   mem_rdata;
  logic                bus_own;
  logic                mem_req;
  bus_op_s             mem_op;
  logic [1:0]          chan_irq;
  int                  mismatches = 0;
  int                  check_count = 0;
  int                  cyc = 0;
  dma_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin_0(ext_irq_pin_0),
    .ext_irq_pin_1(ext_irq_pin_1), .periph_irq(periph_irq), .mem_sw_wait(mem_sw_wait),
    .mem_rdata(mem_rdata), .bus_own(bus_own), .mem_req(mem_req), .mem_op(mem_op), .chan_irq(chan_irq));
  mem_model mem (.clk_sys(clk_sys), .mem_req(mem_req), .mem_op(mem_op), .mem_rdata(mem_rdata));
  // ==========================================================
  // helpers
  task automatic stop_test();
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [7:0] ra(input logic ch, input logic [3:0] off);
    return {3'b000, ch, off};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(20'(reg_rdata), 20'(e));
  endtask
  // waits for one whole transfer and collects its interrupts
  task automatic run(output logic [1:0] irq);
    logic seen;
    int   n;
    irq = 2'b00;
    seen = 1'b0;
    for (n = 0; n < 60; n++)
    begin
      @(posedge clk_sys);
      #1;
      irq = irq | chan_irq;
      if (bus_own === 1'b1)
        seen = 1'b1;
      else if (seen)
        break;
    end
    @(posedge clk_sys);
    #1;
    irq = irq | chan_irq;
    chk(20'(seen), 20'h00001);
  endtask
  task automatic go(input logic ch, output logic [1:0] irq);
    wr(ra(ch, OFF_SWTRIG), 16'h0000);
    run(irq);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_reset();
    rc(ra(1'b0, OFF_CTRL), 16'h0000);
    rc(ra(1'b1, OFF_SEL), 16'h0000);
    rc(ra(1'b1, OFF_COUNT), 16'h0000);
    wr(8'hE0, 16'hFFFF);
    rc(8'hE0, 16'h0000);
  endtask
  task automatic s_single();
    logic [1:0] irq;
    int         i;
    for (i = 0; i < 3; i++)
      mem.m[12'h400 + i] = 8'(8'hA0 + i);
    wr(ra(1'b0, OFF_SRC_LO), 16'h0400);
    wr(ra(1'b0, OFF_DST_LO), 16'h0500);
    wr(ra(1'b0, OFF_RELOAD), 16'h0002);
    wr(ra(1'b0, OFF_CTRL), 16'h0015);
    for (i = 0; i < 3; i++)
    begin
      go(1'b0, irq);
      chk(20'(mem.m[12'h500]), 20'(8'hA0 + i));
      chk(20'(irq), (i == 2) ? 20'h00001 : 20'h00000);
      if (i < 2)
      begin
        rc(ra(1'b0, OFF_COUNT), 16'(1 - i));
        rc(ra(1'b0, OFF_SRC_LO), 16'(16'h0401 + i));
      end
    end
    rc(ra(1'b0, OFF_CTRL), 16'h0014);
  endtask
  task automatic s_repeat();
    logic [1:0] irq;
    int         j;
    mem.m[12'h601] = 8'h34;
    mem.m[12'h602] = 8'h12;
    @(posedge clk_sys);
    mem_sw_wait <= 1'b1;
    wr(ra(1'b1, OFF_SRC_LO), 16'h0601);
    wr(ra(1'b1, OFF_DST_LO), 16'h0701);
    wr(ra(1'b1, OFF_RELOAD), 16'h0000);
    wr(ra(1'b1, OFF_CTRL), 16'h0029);
    wr(ra(1'b1, OFF_SRC_LO), 16'h0999);
    for (j = 0; j < 2; j++)
    begin
      go(1'b1, irq);
      chk(20'(irq), 20'h00002);
    end
    for (j = 0; j < 4; j++)
      chk(20'(mem.m[12'h701 + j]), j[0] ? 20'h00012 : 20'h00034);
    rc(ra(1'b1, OFF_CTRL), 16'h0029);
    rc(ra(1'b1, OFF_SRC_LO), 16'h0601);
    rc(ra(1'b1, OFF_DST_LO), 16'h0705);
    wr(ra(1'b1, OFF_CTRL), 16'h0029);
    rc(ra(1'b1, OFF_DST_LO), 16'h0701);
    wr(ra(1'b1, OFF_CTRL), 16'h0038);
    rc(ra(1'b1, OFF_CTRL), 16'h0018);
    @(posedge clk_sys);
    mem_sw_wait <= 1'b0;
  endtask
  task automatic s_pin();
    logic [1:0] irq;
    wr(ra(1'b0, OFF_SEL), 16'h0002);
    wr(ra(1'b0, OFF_CTRL), 16'h0004);
    @(posedge clk_sys);
    ext_irq_pin_0 <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rc(ra(1'b0, OFF_CTRL), 16'h0006);
    wr(ra(1'b0, OFF_CTRL), 16'h0004);
    wr(ra(1'b0, OFF_CTRL), 16'h0006);
    rc(ra(1'b0, OFF_CTRL), 16'h0004);
    @(posedge clk_sys);
    ext_irq_pin_0 <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rc(ra(1'b0, OFF_CTRL), 16'h0006);
    wr(ra(1'b0, OFF_CTRL), 16'h0017);
    run(irq);
    rc(ra(1'b0, OFF_CTRL), 16'h0015);
    wr(ra(1'b1, OFF_SEL), 16'h0001);
    wr(ra(1'b1, OFF_CTRL), 16'h0018);
    ext_irq_pin_1 <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rc(ra(1'b1, OFF_CTRL), 16'h001A);
    wr(ra(1'b1, OFF_CTRL), 16'h0018);
    ext_irq_pin_1 <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rc(ra(1'b1, OFF_CTRL), 16'h0018);
  endtask
  task automatic s_prio();
    int n;
    wr(ra(1'b0, OFF_CTRL), 16'h0000);
    wr(ra(1'b0, OFF_DST_LO), 16'h0510);
    wr(ra(1'b0, OFF_SEL), 16'h0003);
    wr(ra(1'b0, OFF_CTRL), 16'h0005);
    wr(ra(1'b1, OFF_SRC_LO), 16'h0401);
    wr(ra(1'b1, OFF_DST_LO), 16'h0520);
    wr(ra(1'b1, OFF_SEL), 16'h0012);
    wr(ra(1'b1, OFF_CTRL), 16'h0005);
    mem.wlog.delete();
    @(posedge clk_sys);
    periph_irq <= 16'h8001;
    @(posedge clk_sys);
    periph_irq <= 16'h0000;
    for (n = 0; n < 100 && mem.wlog.size() < 2; n++)
      @(posedge clk_sys);
    chk(20'(mem.wlog.size()), 20'h00002);
    chk(mem.wlog[0], 20'h00510);
    chk(mem.wlog[1], 20'h00520);
  endtask
  task automatic s_word();
    logic [1:0] irq;
    mem.m[12'h800] = 8'hCD;
    mem.m[12'h801] = 8'hAB;
    wr(ra(1'b1, OFF_SEL), 16'h0000);
    wr(ra(1'b1, OFF_SRC_LO), 16'h0800);
    wr(ra(1'b1, OFF_DST_LO), 16'h0900);
    wr(ra(1'b1, OFF_CTRL), 16'h0001);
    go(1'b1, irq);
    chk(20'({mem.m[12'h901], mem.m[12'h900]}), 20'h0ABCD);
    chk(20'(irq), 20'h00002);
    wr(ra(1'b1, OFF_DST_LO), 16'h0020);
    wr(ra(1'b1, OFF_CTRL), 16'h0001);
    mem.wlog.delete();
    go(1'b1, irq);
    chk(20'(mem.wlog.size()), 20'h00000);
  endtask
  // ==========================================================
  // clock, timeout and main sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    s_reset();
    s_single();
    s_repeat();
    s_pin();
    s_prio();
    s_word();
    stop_test();
  end
endmodule
`default_nettype wire
